// ===== pgrw_datapath.sv
// Planar graphics read/write data path with index/data register port.
//
// Function
// - Mode 0 enabled planes write fill bit replicated, merged through bit mask.
// - Mode 0 disabled planes write rotated CPU byte after logical function.
// - Compare read returns ones where all participating planes match compare colour.
// - Plain read returns selected plane; ignored when chain-four is set.
// - Function field: 00 pass, 01 AND, 10 OR, 11 XOR with latches.
// - Function uses the mode's source byte (rotated CPU byte, fill bit or expanded CPU bit) and latches from the last read.
// - Mode 0 rotates CPU byte right by rotate count, wrapping.
// - Read plane select picks plane 0-3; no effect in compare reads.
// - Odd/even: select 00/01 gives planes 0/1, 10/11 gives 2/3.
// - 256-colour bit selects that load format, else shift-format bit governs.
// - Without 256-colour, palette drives six low outputs, colour select the top two.
// - Interleaved format splits even and odd bits; MSB always shifts first.
// - Odd/even access: even addresses reach planes 0/2, odd planes 1/3.
// - Two-bit write mode field selects modes 0 to 3.
// - Mode 1 writes the 32 latched bits, ignoring CPU data.
// - Every display read loads all four latches.
// - Mode 2 expands CPU bits 0-3 to bytes, merged through bit mask.
// - Mask zero keeps latched bit, one passes new data, all planes.
// - Planes with don't-care bit zero are excluded from comparison.
`timescale 1ns/1ps
`default_nettype none
`include "pgrw_defines.svh"
module pgrw_datapath (
  input wire logic clk,
  input wire logic reset,
  input wire logic idx_wr,
  input wire logic [7:0] idx_wdata,
  output logic [7:0] idx_rdata,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  output logic [7:0] data_rdata,
  input wire logic chain_four,
  input wire logic host_addr0,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic [31:0] plane_rdata,
  output logic [31:0] plane_wdata,
  output logic [3:0] plane_wen,
  input wire logic [7:0] palette_entry,
  output logic [3:0] palette_index,
  input wire logic [1:0] colour_select_hi,
  input wire logic dot_en,
  input wire logic shift_load,
  output logic [7:0] video_out,
  output logic [7:0] colour256_pixel
);
  import pgrw_pkg::*;

  // Register file.
  logic [3:0] index_reg;
  logic [3:0] plane_fill_value_reg;
  logic [3:0] plane_fill_enable_reg;
  logic [3:0] compare_colour_reg;
  logic [4:0] rotate_and_function_reg;
  logic [1:0] read_plane_select_reg;
  logic [6:0] plane_access_mode_reg;
  logic [3:0] misc_reg;
  logic [3:0] dont_care_reg;
  logic [7:0] bit_mask_reg;
  pgrw_planes_t latch_reg;
  logic [7:0] cpu_rdata_reg;
  logic [31:0] plane_wdata_reg;
  logic [3:0] plane_wen_reg;
  logic [7:0] video_reg;
  logic [7:0] pix256_reg;
  logic [3:0] pal_idx_reg;

  // Byte-wide replicate of one bit.
  function automatic logic [7:0] rep8(input logic v);
    rep8 = {8{v}};
  endfunction : rep8

  // Merge new data with latch under a mask.
  function automatic logic [7:0] merge(input logic [7:0] nd, input logic [7:0] lat,
                                       input logic [7:0] m);
    merge = (nd & m) | (lat & ~m);
  endfunction : merge

  // Field decode.
  wire [2:0] rot_count = rotate_and_function_reg[`PGRW_ROT_MSB:`PGRW_ROT_LSB];
  wire [1:0] func_sel = rotate_and_function_reg[`PGRW_FUNC_MSB:`PGRW_FUNC_LSB];
  wire [1:0] wmode_bits = plane_access_mode_reg[`PGRW_WMODE_MSB:`PGRW_WMODE_LSB];
  wire read_compare = plane_access_mode_reg[`PGRW_READ_TYPE_BIT];
  wire odd_even = plane_access_mode_reg[`PGRW_ODD_EVEN_BIT];
  wire shift_fmt = plane_access_mode_reg[`PGRW_SHIFT_FMT_BIT];
  wire colour256 = plane_access_mode_reg[`PGRW_COLOUR256_BIT];
  pgrw_wmode_e wmode;
  pgrw_func_e func;
  assign wmode = pgrw_wmode_e'(wmode_bits);
  assign func = pgrw_func_e'(func_sel);

  // Right rotation of the CPU byte with wrap-around.
  wire [15:0] rot_dbl = {cpu_wdata, cpu_wdata} >> rot_count;
  wire [7:0] cpu_rot = rot_dbl[7:0];

  // Per-plane write data path.
  logic [7:0] wr_byte [4];
  logic [7:0] mask3;
  assign mask3 = cpu_rot & bit_mask_reg;
  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : gp
      logic [7:0] lat;
      logic [7:0] alu_in;
      logic [7:0] alu_out;
      assign lat = latch_reg[8*p +: 8];
      // Source operand before the logical function.
      assign alu_in = (wmode == PGRW_WM_EXPAND) ? rep8(cpu_wdata[p])
        : (wmode == PGRW_WM_MASKED) ? rep8(plane_fill_value_reg[p])
        : plane_fill_enable_reg[p] ? rep8(plane_fill_value_reg[p])
        : cpu_rot;
      // Logical function with the latch.
      always_comb begin
        unique case (func)
          PGRW_FN_PASS: alu_out = alu_in;
          PGRW_FN_AND: alu_out = alu_in & lat;
          PGRW_FN_OR: alu_out = alu_in | lat;
          PGRW_FN_XOR: alu_out = alu_in ^ lat;
        endcase
      end
      // Final byte per mode with mask applied to all planes alike.
      assign wr_byte[p] = (wmode == PGRW_WM_COPY) ? lat
        : (wmode == PGRW_WM_MASKED) ? merge(alu_out, lat, mask3)
        : merge(alu_out, lat, bit_mask_reg);
    end
  endgenerate

  // Plane enables for host access: odd/even routes by address bit.
  wire [3:0] wr_planes = odd_even ? (host_addr0 ? 4'b1010 : 4'b0101) : 4'b1111;

  // Read plane choice, chained in odd/even mode.
  wire [1:0] rd_sel = odd_even ? {read_plane_select_reg[1], host_addr0}
                               : read_plane_select_reg;
  wire [7:0] plain_byte = chain_four ? plane_rdata[8*{1'b0, host_addr0} +: 8]
                                     : plane_rdata[8*rd_sel +: 8];

  // Colour compare: match per plane, don't-care planes always match.
  logic [7:0] cmp_byte;
  always_comb begin
    cmp_byte = 8'hff;
    for (int i = 0; i < 4; i++) begin
      if (dont_care_reg[i]) begin
        cmp_byte = cmp_byte & ~(plane_rdata[8*i +: 8] ^ rep8(compare_colour_reg[i]));
      end
    end
  end

  // Index port write and register writes through the data port.
  always_ff @(posedge clk) begin
    if (reset) begin
      index_reg <= 4'h0;
      plane_fill_value_reg <= `PGRW_RST_NIBBLE;
      plane_fill_enable_reg <= `PGRW_RST_NIBBLE;
      compare_colour_reg <= `PGRW_RST_NIBBLE;
      rotate_and_function_reg <= 5'h00;
      read_plane_select_reg <= 2'h0;
      plane_access_mode_reg <= 7'h00;
      misc_reg <= `PGRW_RST_NIBBLE;
      dont_care_reg <= `PGRW_RST_DONT_CARE;
      bit_mask_reg <= `PGRW_RST_MASK;
    end else begin
      if (idx_wr) begin
        index_reg <= idx_wdata[3:0];
      end
      if (data_wr) begin
        unique case (index_reg)
          `PGRW_IDX_FILL_VALUE: plane_fill_value_reg <= data_wdata[3:0];
          `PGRW_IDX_FILL_ENABLE: plane_fill_enable_reg <= data_wdata[3:0];
          `PGRW_IDX_CMP_COLOUR: compare_colour_reg <= data_wdata[3:0];
          `PGRW_IDX_ROT_FUNC: rotate_and_function_reg <= data_wdata[4:0];
          `PGRW_IDX_READ_PLANE: read_plane_select_reg <= data_wdata[1:0];
          `PGRW_IDX_ACCESS_MODE: plane_access_mode_reg <= {data_wdata[6:3], 1'b0,
                                                           data_wdata[1:0]};
          `PGRW_IDX_MISC: misc_reg <= data_wdata[3:0];
          `PGRW_IDX_DONT_CARE: dont_care_reg <= data_wdata[3:0];
          `PGRW_IDX_BIT_MASK: bit_mask_reg <= data_wdata;
          default: ;
        endcase
      end
    end
  end

  // Register read-back, reserved bits zero.
  assign idx_rdata = {4'h0, index_reg};
  always_comb begin
    unique case (index_reg)
      `PGRW_IDX_FILL_VALUE: data_rdata = {4'h0, plane_fill_value_reg};
      `PGRW_IDX_FILL_ENABLE: data_rdata = {4'h0, plane_fill_enable_reg};
      `PGRW_IDX_CMP_COLOUR: data_rdata = {4'h0, compare_colour_reg};
      `PGRW_IDX_ROT_FUNC: data_rdata = {3'h0, rotate_and_function_reg};
      `PGRW_IDX_READ_PLANE: data_rdata = {6'h00, read_plane_select_reg};
      `PGRW_IDX_ACCESS_MODE: data_rdata = {1'b0, plane_access_mode_reg};
      `PGRW_IDX_MISC: data_rdata = {4'h0, misc_reg};
      `PGRW_IDX_DONT_CARE: data_rdata = {4'h0, dont_care_reg};
      `PGRW_IDX_BIT_MASK: data_rdata = bit_mask_reg;
      default: data_rdata = `PGRW_RST_BYTE;
    endcase
  end

  // Display memory reads load latches and return data; writes drive planes.
  always_ff @(posedge clk) begin
    if (reset) begin
      latch_reg <= 32'h0000_0000;
      cpu_rdata_reg <= `PGRW_RST_BYTE;
      plane_wdata_reg <= 32'h0000_0000;
      plane_wen_reg <= 4'h0;
    end else begin
      plane_wen_reg <= mem_wr ? wr_planes : 4'h0;
      if (mem_rd) begin
        latch_reg <= plane_rdata;
        cpu_rdata_reg <= read_compare ? cmp_byte : plain_byte;
      end
      if (mem_wr) begin
        plane_wdata_reg <= {wr_byte[3], wr_byte[2], wr_byte[1], wr_byte[0]};
      end
    end
  end
  assign cpu_rdata = cpu_rdata_reg;
  assign plane_wdata = plane_wdata_reg;
  assign plane_wen = plane_wen_reg;

  // Video shifter fed with plane data.
  pgrw_shift_if sif ();
  assign sif.load = shift_load & dot_en;
  assign sif.shift = dot_en;
  assign sif.colour256 = colour256;
  assign sif.cga_format = shift_fmt & ~colour256;
  assign sif.planes = plane_rdata;
  pgrw_shifter u_shifter (
    .clk(clk),
    .reset(reset),
    .sif(sif)
  );

  // Pixel out: palette path or 256-colour byte assembly over two dots.
  logic half_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      video_reg <= 8'h00;
      pix256_reg <= 8'h00;
      pal_idx_reg <= 4'h0;
      half_reg <= 1'b0;
    end else if (dot_en) begin
      pal_idx_reg <= sif.pixel;
      half_reg <= (colour256 && !sif.load) ? ~half_reg : 1'b0; // Loads start a pixel pair.
      pix256_reg <= {pix256_reg[3:0], sif.pixel};
      if (colour256) begin
        video_reg <= half_reg ? {pix256_reg[3:0], sif.pixel} : video_reg;
      end else begin
        video_reg <= {colour_select_hi, palette_entry[5:0]};
      end
    end
  end
  assign palette_index = pal_idx_reg;
  assign video_out = video_reg;
  assign colour256_pixel = pix256_reg;
endmodule : pgrw_datapath
`default_nettype wire

// ===== pgrw_datapath_props.sv
// Concurrent checks on the ports of the planar read/write data path.
`timescale 1ns/1ps
`default_nettype none
module pgrw_datapath_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic idx_wr,
  input wire logic [7:0] idx_wdata,
  input wire logic [7:0] idx_rdata,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic [7:0] data_rdata,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] cpu_rdata,
  input wire logic [31:0] plane_wdata,
  input wire logic [3:0] plane_wen
);
  // All checks sample on the rising edge and rest during reset.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // The index written is the index read back, upper bits clear.
  property p_index_echo;
    logic [3:0] v;
    (idx_wr, v = idx_wdata[3:0]) |=> idx_rdata == {4'h0, v};
  endproperty
  a_index_echo: assert property (p_index_echo)
    else $error("index readback differs from index written");
  a_mask_echo: assert property (idx_rdata == 8'h08 && data_wr && !idx_wr |=>
    data_rdata == $past(data_wdata)) else $error("bit mask readback differs");
  a_reserved_zero: assert property (idx_rdata != 8'h03 && idx_rdata != 8'h05 &&
    idx_rdata != 8'h08 |-> data_rdata[7:4] == 4'h0) else $error("reserved bits set");
  a_wen_after_write: assert property (mem_wr |=> plane_wen != 4'h0)
    else $error("no plane enable after a write");
  a_wen_has_cause: assert property (plane_wen != 4'h0 |-> $past(mem_wr))
    else $error("plane enable without a write");
  a_wen_single_pulse: assert property (plane_wen != 4'h0 && !mem_wr |=> plane_wen == 4'h0)
    else $error("plane enable held too long");
  a_wen_pattern: assert property (plane_wen inside {4'h0, 4'h5, 4'ha, 4'hf})
    else $error("plane enable pattern illegal");
  a_rdata_holds: assert property (!mem_rd |=> $stable(cpu_rdata))
    else $error("read result changed without a read");
  a_wdata_holds: assert property (!mem_wr |=> $stable(plane_wdata))
    else $error("write data changed without a write");
  // Main scenarios reached.
  c_read_write: cover property (mem_rd ##2 mem_wr);
  c_odd_even: cover property (plane_wen == 4'h5);
  c_mask_write: cover property (data_wr && idx_rdata == 8'h08);
endmodule : pgrw_datapath_props
bind pgrw_datapath pgrw_datapath_props props_u (
  .clk(clk), .reset(reset), .idx_wr(idx_wr), .idx_wdata(idx_wdata),
  .idx_rdata(idx_rdata), .data_wr(data_wr), .data_wdata(data_wdata),
  .data_rdata(data_rdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
  .cpu_rdata(cpu_rdata), .plane_wdata(plane_wdata), .plane_wen(plane_wen)
);
`default_nettype wire

// ===== pgrw_defines.svh
// Register offsets, field positions and reset values of the planar read/write data path.
`ifndef PGRW_DEFINES_SVH
`define PGRW_DEFINES_SVH
`define PGRW_IDX_FILL_VALUE 4'h0
`define PGRW_IDX_FILL_ENABLE 4'h1
`define PGRW_IDX_CMP_COLOUR 4'h2
`define PGRW_IDX_ROT_FUNC 4'h3
`define PGRW_IDX_READ_PLANE 4'h4
`define PGRW_IDX_ACCESS_MODE 4'h5
`define PGRW_IDX_MISC 4'h6
`define PGRW_IDX_DONT_CARE 4'h7
`define PGRW_IDX_BIT_MASK 4'h8
`define PGRW_ROT_LSB 0
`define PGRW_ROT_MSB 2
`define PGRW_FUNC_LSB 3
`define PGRW_FUNC_MSB 4
`define PGRW_WMODE_LSB 0
`define PGRW_WMODE_MSB 1
`define PGRW_READ_TYPE_BIT 3
`define PGRW_ODD_EVEN_BIT 4
`define PGRW_SHIFT_FMT_BIT 5
`define PGRW_COLOUR256_BIT 6
`define PGRW_RST_NIBBLE 4'h0
`define PGRW_RST_BYTE 8'h00
`define PGRW_RST_MASK 8'hff
`define PGRW_RST_DONT_CARE 4'hf
`endif

// ===== pgrw_mem_model.sv
// Display memory model holding one four-plane word for the data path.
`timescale 1ns/1ps
`default_nettype none
module pgrw_mem_model (
  input wire logic clk,
  input wire logic load,
  input wire logic [31:0] load_word,
  input wire logic mem_rd,
  input wire logic [3:0] plane_wen,
  input wire logic [31:0] plane_wdata,
  output logic [31:0] plane_rdata
);
  logic [31:0] word_reg;
  // Outside a read the bus shows the inverse, so stale data never looks valid.
  assign plane_rdata = mem_rd ? word_reg : ~word_reg;
  // Preload from the bench, or store each enabled plane byte.
  always_ff @(posedge clk) begin
    if (load) begin
      word_reg <= load_word;
    end else begin
      for (int p = 0; p < 4; p++) begin
        if (plane_wen[p]) begin
          word_reg[p*8+:8] <= plane_wdata[p*8+:8];
        end
      end
    end
  end
endmodule : pgrw_mem_model
`default_nettype wire

// ===== pgrw_pkg.sv
// Types shared by the planar read/write data path.
package pgrw_pkg;
  typedef enum logic [1:0] {
    PGRW_FN_PASS = 2'b00,
    PGRW_FN_AND = 2'b01,
    PGRW_FN_OR = 2'b10,
    PGRW_FN_XOR = 2'b11
  } pgrw_func_e;
  typedef enum logic [1:0] {
    PGRW_WM_FILL = 2'b00,
    PGRW_WM_COPY = 2'b01,
    PGRW_WM_EXPAND = 2'b10,
    PGRW_WM_MASKED = 2'b11
  } pgrw_wmode_e;
  typedef logic [31:0] pgrw_planes_t;
endpackage : pgrw_pkg

// ===== pgrw_shift_if.sv
// Interface carrying plane data and load control to the video shifter.
`timescale 1ns/1ps
`default_nettype none
interface pgrw_shift_if;
  logic load;
  logic shift;
  logic colour256;
  logic cga_format;
  logic [31:0] planes;
  logic [3:0] pixel;
  modport src (output load, output shift, output colour256, output cga_format,
               output planes, input pixel);
  modport shifter (input load, input shift, input colour256, input cga_format,
                   input planes, output pixel);
endinterface : pgrw_shift_if
`default_nettype wire

// ===== pgrw_shifter.sv
// Four video shift registers with normal, interleaved and 256-colour loading.
`timescale 1ns/1ps
`default_nettype none
module pgrw_shifter (
  input wire logic clk,
  input wire logic reset,
  pgrw_shift_if.shifter sif
);
  logic [7:0] sh_reg [4];
  logic [7:0] ld_cga [4];
  logic [7:0] ld_256 [4];
  // Load patterns: interleaved format pairs two planes, 256-colour makes each plane one pixel.
  genvar g, b;
  generate
    for (g = 0; g < 4; g++) begin : gl
      for (b = 0; b < 4; b++) begin : gb
        // Shifter g takes bits of parity g%2 from plane 2*(g/2), then from the next plane.
        assign ld_cga[g][7-b] = sif.planes[16*(g/2) + 6 - 2*b + g%2];
        assign ld_cga[g][3-b] = sif.planes[16*(g/2) + 14 - 2*b + g%2];
        // Shifter g takes bit g of both nibbles of plane b, high nibble first.
        assign ld_256[g][7-2*b] = sif.planes[8*b + 4 + g];
        assign ld_256[g][6-2*b] = sif.planes[8*b + g];
      end
      // Shift left so the most significant bit leaves first.
      always_ff @(posedge clk) begin
        if (reset) begin
          sh_reg[g] <= 8'h00;
        end else if (sif.load) begin
          sh_reg[g] <= sif.colour256 ? ld_256[g]
            : sif.cga_format ? ld_cga[g] : sif.planes[8*g +: 8];
        end else if (sif.shift) begin
          sh_reg[g] <= {sh_reg[g][6:0], 1'b0};
        end
      end
      assign sif.pixel[g] = sh_reg[g][7];
    end
  endgenerate
endmodule : pgrw_shifter
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the planar read/write data path.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] RMASK [0:9] = '{8'h0f, 8'h0f, 8'h0f, 8'h1f, 8'h03, 8'h7b, 8'h0f,
    8'h0f, 8'hff, 8'h00};
  localparam logic [7:0] RST [0:9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h0f, 8'hff, 8'h00};
  logic clk = 1'b0, reset = 1'b1, idx_wr = 1'b0, data_wr = 1'b0, chain_four = 1'b0;
  logic host_addr0 = 1'b0, mem_rd = 1'b0, mem_wr = 1'b0, dot_en = 1'b0, shift_load = 1'b0;
  logic load = 1'b0;
  logic [7:0] idx_wdata = 8'h00, data_wdata = 8'h00, cpu_wdata = 8'h00, palette_entry = 8'h00;
  logic [1:0] colour_select_hi = 2'h0;
  logic [31:0] load_word = 32'h0, word = 32'h0, lat = 32'h0, rnd = 32'ha2df3007;
  logic [7:0] idx_rdata, data_rdata, cpu_rdata, video_out, colour256_pixel;
  logic [31:0] plane_rdata, plane_wdata;
  logic [3:0] plane_wen, palette_index;
  logic [7:0] r [0:9];
  int err_total = 0, checked = 0, cyc = 0;
  // Clock of 50 ns period.
  always #25 clk = ~clk;
  pgrw_datapath dut_u (
    .clk(clk), .reset(reset), .idx_wr(idx_wr), .idx_wdata(idx_wdata),
    .idx_rdata(idx_rdata), .data_wr(data_wr), .data_wdata(data_wdata),
    .data_rdata(data_rdata), .chain_four(chain_four), .host_addr0(host_addr0),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .plane_rdata(plane_rdata), .plane_wdata(plane_wdata), .plane_wen(plane_wen),
    .palette_entry(palette_entry), .palette_index(palette_index),
    .colour_select_hi(colour_select_hi), .dot_en(dot_en), .shift_load(shift_load),
    .video_out(video_out), .colour256_pixel(colour256_pixel)
  );
  pgrw_mem_model mem_u (
    .clk(clk), .load(load), .load_word(load_word), .mem_rd(mem_rd),
    .plane_wen(plane_wen), .plane_wdata(plane_wdata), .plane_rdata(plane_rdata)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Logical combine of the mode's source byte (rotated, fill or expanded data) with one latch byte.
  function automatic logic [7:0] fn(input logic [7:0] a, input logic [7:0] b);
    return r[3][4] ? (r[3][3] ? a ^ b : a | b) : (r[3][3] ? a & b : a);
  endfunction : fn
  // Expected plane data of a write of CPU byte c.
  function automatic logic [31:0] exp_wr(input logic [7:0] c);
    logic [7:0] rt, m, d, l;
    logic [15:0] cc;
    logic [31:0] o;
    cc = {c, c} >> r[3][2:0];
    rt = cc[7:0];
    m = (r[5][1:0] == 2'h3) ? (rt & r[8]) : r[8];
    for (int p = 0; p < 4; p++) begin
      l = lat[p*8+:8];
      case (r[5][1:0])
        2'h0: d = fn(r[1][p] ? {8{r[0][p]}} : rt, l);
        2'h1: d = l;
        2'h2: d = fn({8{c[p]}}, l);
        default: d = fn({8{r[0][p]}}, l);
      endcase
      o[p*8+:8] = (d & m) | (l & ~m);
    end
    return o;
  endfunction : exp_wr
  // Expected read result, plain or colour compare.
  function automatic logic [7:0] exp_rd();
    logic [7:0] x;
    logic [1:0] s;
    x = 8'hff;
    s = r[5][4] ? {r[4][1], host_addr0} : r[4][1:0];
    for (int p = 0; p < 4; p++) begin
      if (r[7][p]) x &= ~(word[p*8+:8] ^ {8{r[2][p]}});
    end
    return r[5][3] ? x : (chain_four ? word[host_addr0*8+:8] : word[s*8+:8]);
  endfunction : exp_rd
  // Expected pixel nibble k after a shifter load of planes q in format f.
  function automatic logic [3:0] nib(input logic [31:0] q, input int k, input logic [1:0] f);
    logic [3:0] n;
    for (int g = 0; g < 4; g++) begin
      if (f[1]) n[g] = q[8*(k/2) + 4*(1 - k%2) + g];
      else if (f[0]) n[g] = q[16*(g/2) + 8*(k/4) + 2*(3 - k%4) + g%2];
      else n[g] = q[8*g + 7 - k];
    end
    return n;
  endfunction : nib
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wreg(input int i, input logic [7:0] v);
    idx_wr <= 1'b1;
    idx_wdata <= 8'(i);
    @(posedge clk);
    idx_wr <= 1'b0;
    data_wr <= 1'b1;
    data_wdata <= v;
    @(posedge clk);
    data_wr <= 1'b0;
    r[i] = v & RMASK[i];
  endtask : wreg
  task automatic rreg(input int i);
    idx_wr <= 1'b1;
    idx_wdata <= 8'(i);
    @(posedge clk);
    idx_wr <= 1'b0;
    @(posedge clk);
    chk(idx_rdata, i);
    chk(data_rdata, r[i]);
  endtask : rreg
  task automatic mread();
    load <= 1'b1;
    load_word <= rnd;
    word = rnd;
    @(posedge clk);
    load <= 1'b0;
    mem_rd <= 1'b1;
    host_addr0 <= rnd[8];
    chain_four <= rnd[9];
    @(posedge clk);
    mem_rd <= 1'b0;
    @(posedge clk);
    chk(cpu_rdata, exp_rd());
    lat = word;
    chain_four <= 1'b0;
  endtask : mread
  task automatic mwrite(input logic [7:0] c);
    mem_wr <= 1'b1;
    cpu_wdata <= c;
    @(posedge clk);
    mem_wr <= 1'b0;
    @(posedge clk);
    chk(plane_wdata, exp_wr(c));
    chk(plane_wen, r[5][4] ? (host_addr0 ? 4'ha : 4'h5) : 4'hf);
  endtask : mwrite
  // Load the shifters in format f (bit 1 256-colour, bit 0 interleaved), follow eight dots.
  task automatic vid(input logic [1:0] f);
    wreg(5, {1'b0, f, 5'h00});
    rnd = lfsr(rnd);
    load <= 1'b1;
    load_word <= rnd;
    word = ~rnd;
    {colour_select_hi, palette_entry} <= rnd[9:0];
    dot_en <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    shift_load <= 1'b1;
    @(posedge clk);
    shift_load <= 1'b0;
    for (int m = 0; m < 9; m++) begin
      @(posedge clk);
      if (m > 0) chk(palette_index, nib(word, m - 1, f));
      if (m > 1) chk(colour256_pixel, {nib(word, m - 2, f), nib(word, m - 1, f)});
      if (f[1] && m > 1) chk(video_out, word[8*(m/2-1)+:8]);
      if (!f[1] && m > 0) chk(video_out, {colour_select_hi, palette_entry[5:0]});
    end
  endtask : vid
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  // Register table first, then random read and write traffic in every mode.
  initial begin
    foreach (r[i]) r[i] = RST[i];
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 10; i++) rreg(i);
    for (int i = 0; i < 10; i++) begin
      wreg(i, 8'hff);
      rreg(i);
    end
    $display("test registers done");
    repeat (300) begin
      for (int i = 0; i < 9; i++) begin
        rnd = lfsr(rnd);
        wreg(i, rnd[7:0]);
      end
      rnd = lfsr(rnd);
      {palette_entry, colour_select_hi, dot_en, shift_load} <= rnd[19:8];
      mread();
      rnd = lfsr(rnd);
      mwrite(rnd[31:24]);
    end
    $display("test data path done");
    for (int f = 0; f < 4; f++) vid(2'(f));
    $display("test video done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
